// ==== esa_aggregator.sv ====
// Purpose: system event flags, global summary and receive-data event signal
// Assumes: write/read strobes and event pulses come from logic on clk_sys
// Notes:   group pending inputs and transceiver state are pins, synchronised here
`timescale 1ns/1ps

// Functional notes
// [R01] writing 1 clears a flag, writing 0 leaves it unchanged
// [R02] summary bit 3 reads 1 while any wake pin event is pending
// [R03] summary bit 2 reads 1 while any transceiver event is pending
// [R04] summary bit 1 reads 1 while any supply event is pending
// [R05] summary bit 0 reads 1 while any system event is pending
// [R06] power-on flag set when device leaves off mode
// [R07] overtemperature warning sets bit 2, not captured in sleep
// [R08] serial clock count other than 16, 24, 32 sets serial failure, not in sleep
// [R09] illegal watchdog mode, period or mode control code sets serial failure
// [R10] write to locked register sets serial failure
// [R11] watchdog overflow in window or timeout mode sets watchdog failure flag
// [R12] early watchdog service in window mode sets watchdog failure flag
// [R13] window mode watchdog failure starts system reset at once
// [R14] timeout overflow resets system only if watchdog failure already set
// [R15] power-on and watchdog always captured, others need their capture enable
// [R16] receive-data low while transceiver offline, supply on and event pending
// [R17] clear releases receive-data, starts delay; low again after delay if pending
// [R18] reserved bits read 0, ignore writes; summary ignores all writes
module esa_aggregator #(
   parameter int EVENT_DELAY_CYC = esa_pkg::ESA_EVENT_DELAY_CYC
) (
   // clock and reset
   input  wire logic       clk_sys,
   input  wire logic       srst,
   // register port
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic      [7:0] reg_rdata,
   // event pulses from on-chip logic
   input  wire logic       off_mode_exit,
   input  wire logic       overtemp_warn,
   input  wire logic       serial_bad_count,
   input  wire logic [5:0] serial_bit_count,
   input  wire logic       serial_frame_end,
   input  wire logic       illegal_code_write,
   input  wire logic       locked_write,
   input  wire logic       wdt_overflow,
   input  wire logic       wdt_early,
   input  wire logic       wdt_window_mode,
   input  wire logic       wdt_timeout_mode,
   // capture enables and mode levels
   input  wire logic       otw_capture_en,
   input  wire logic       sf_capture_en,
   input  wire logic       sleep_mode,
   // asynchronous group pending levels and transceiver state
   input  wire logic       supply_group_in,
   input  wire logic       transceiver_group_in,
   input  wire logic       wake_pin_group_in,
   input  wire logic       trx_offline,
   input  wire logic       main_supply_on,
   input  wire logic       reset_pin_low,
   // outputs
   output logic            rxd_out,
   output logic            system_reset_req,
   output logic            power_on_flag,
   output logic            overtemp_warning_flag,
   output logic            serial_failure_flag,
   output logic            watchdog_failure_flag
);
   import esa_pkg::*;

   logic [5:0] pin_sync;
   logic       supply_group_pending;
   logic       transceiver_group_pending;
   logic       wake_pin_group_pending;
   logic       system_group_pending;
   logic       off_s;
   logic       on_s;
   logic       rstn_low_s;
   logic [7:0] sys_flags;
   logic [7:0] next_sys_flags;
   logic [7:0] clr;
   logic [7:0] set;
   logic [7:0] summary;
   logic       any_pending;
   logic       any_clear;
   logic       delay_run;
   logic [31:0] delay_cnt;
   logic       bad_count;

   esa_sync #(.W(6)) u_sync (
      .clk_sys (clk_sys),
      .srst    (srst),
      .d       ({supply_group_in, transceiver_group_in, wake_pin_group_in,
                 trx_offline, main_supply_on, reset_pin_low}),
      .q       (pin_sync)
   );
   assign supply_group_pending      = pin_sync[5];
   assign transceiver_group_pending = pin_sync[4];
   assign wake_pin_group_pending    = pin_sync[3];
   assign off_s                     = pin_sync[2];
   assign on_s                      = pin_sync[1];
   assign rstn_low_s                = pin_sync[0];

   // legal frame lengths are 16, 24 and 32 clocks
   function automatic logic legal_count(input logic [5:0] n);
      logic ok;
      ok = (n == 6'h10) || (n == 6'h18) || (n == 6'h20);
      return ok;
   endfunction

   // frame length check
   always_comb begin
      bad_count = serial_bad_count;
      if (serial_frame_end && !legal_count(serial_bit_count)) begin
         bad_count = 1'b1; // see [R08]
      end
   end

   // set terms
   always_comb begin
      set = 8'h00;
      set[ESA_BIT_PO]  = off_mode_exit; // see [R06] see [R15]
      set[ESA_BIT_OTW] = overtemp_warn && otw_capture_en && !sleep_mode; // see [R07] see [R15]
      set[ESA_BIT_SF]  = (bad_count || illegal_code_write || locked_write)
                         && sf_capture_en && !sleep_mode; // see [R08] see [R09] see [R10] see [R15]
      set[ESA_BIT_WDF] = (wdt_overflow && (wdt_window_mode || wdt_timeout_mode))
                         || (wdt_early && wdt_window_mode); // see [R11] see [R12] see [R15]
   end

   assign clr = (reg_wr && reg_addr == ESA_ADDR_SYSTEM) ? (reg_wdata & ESA_SYS_MASK) : 8'h00;

   // set wins over clear, reserved bits held at zero
   assign next_sys_flags = ((sys_flags & ~clr) | set) & ESA_SYS_MASK; // see [R01] see [R18]

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         sys_flags <= ESA_SYS_RESET;
      end else begin
         sys_flags <= next_sys_flags;
      end
   end

   assign system_group_pending = |sys_flags;
   always_comb begin
      summary = 8'h00;
      summary[ESA_SUM_WAKE]   = wake_pin_group_pending;    // see [R02]
      summary[ESA_SUM_TRX]    = transceiver_group_pending; // see [R03]
      summary[ESA_SUM_SUPPLY] = supply_group_pending;      // see [R04]
      summary[ESA_SUM_SYSTEM] = system_group_pending;      // see [R05]
   end

   // read mux; summary has no write path
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         if (reg_addr == ESA_ADDR_SUMMARY) begin
            reg_rdata <= summary; // see [R18]
         end else if (reg_addr == ESA_ADDR_SYSTEM) begin
            reg_rdata <= sys_flags;
         end else begin
            reg_rdata <= 8'h00;
         end
      end
   end

   // watchdog driven system reset
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         system_reset_req <= 1'b0;
      end else begin
         system_reset_req <= ((wdt_overflow || wdt_early) && wdt_window_mode)        // see [R13]
                             || (wdt_overflow && wdt_timeout_mode && sys_flags[ESA_BIT_WDF]); // see [R14]
      end
   end

   // event delay timer and receive-data signalling
   assign any_pending = |summary;
   assign any_clear   = |(clr & sys_flags);

   always_ff @(posedge clk_sys) begin
      if (srst || rstn_low_s) begin
         delay_run <= 1'b0;
         delay_cnt <= 32'h00000000;
      end else if (any_clear) begin
         delay_run <= 1'b1; // see [R17]
         delay_cnt <= 32'h00000000;
      end else if (delay_run) begin
         if (delay_cnt >= 32'(EVENT_DELAY_CYC - 1)) begin
            delay_run <= 1'b0;
         end
         delay_cnt <= delay_cnt + 32'h00000001;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         rxd_out <= 1'b1;
      end else if (any_clear || delay_run) begin
         rxd_out <= 1'b1; // see [R17]
      end else begin
         rxd_out <= !(off_s && on_s && any_pending); // see [R16]
      end
   end

   // flag outputs
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         power_on_flag         <= 1'b0;
         overtemp_warning_flag <= 1'b0;
         serial_failure_flag   <= 1'b0;
         watchdog_failure_flag <= 1'b0;
      end else begin
         power_on_flag         <= next_sys_flags[ESA_BIT_PO];
         overtemp_warning_flag <= next_sys_flags[ESA_BIT_OTW];
         serial_failure_flag   <= next_sys_flags[ESA_BIT_SF];
         watchdog_failure_flag <= next_sys_flags[ESA_BIT_WDF];
      end
   end

   // checks
   AST_W1C: assert property (@(posedge clk_sys) disable iff (srst) // see [R01]
      (reg_wr && reg_addr == ESA_ADDR_SYSTEM && reg_wdata[ESA_BIT_OTW] && !set[ESA_BIT_OTW])
      |=> !sys_flags[ESA_BIT_OTW]) else $error("w1c did not clear");
   AST_W0_KEEP: assert property (@(posedge clk_sys) disable iff (srst) // see [R01]
      (reg_wr && reg_addr == ESA_ADDR_SYSTEM && !reg_wdata[ESA_BIT_PO] && sys_flags[ESA_BIT_PO])
      |=> sys_flags[ESA_BIT_PO]) else $error("zero write changed flag");
   AST_SUM_SYS: assert property (@(posedge clk_sys) disable iff (srst) // see [R05]
      reg_rd && reg_addr == ESA_ADDR_SUMMARY |=> reg_rdata[ESA_SUM_SYSTEM] == $past(|sys_flags))
      else $error("summary system bit wrong");
   AST_SUM_WAKE: assert property (@(posedge clk_sys) disable iff (srst) // see [R02]
      reg_rd && reg_addr == ESA_ADDR_SUMMARY |=> reg_rdata[ESA_SUM_WAKE] == $past(pin_sync[3]))
      else $error("summary wake bit wrong");
   AST_SUM_RSVD: assert property (@(posedge clk_sys) disable iff (srst) // see [R18]
      reg_rd && reg_addr == ESA_ADDR_SUMMARY |=> reg_rdata[7:4] == 4'h0)
      else $error("summary reserved bits set");
   AST_SUM_TRX: assert property (@(posedge clk_sys) disable iff (srst) // see [R03]
      reg_rd && reg_addr == ESA_ADDR_SUMMARY |=> reg_rdata[ESA_SUM_TRX] == $past(pin_sync[4]))
      else $error("summary transceiver bit wrong");
   AST_SUM_SUPPLY: assert property (@(posedge clk_sys) disable iff (srst) // see [R04]
      reg_rd && reg_addr == ESA_ADDR_SUMMARY |=> reg_rdata[ESA_SUM_SUPPLY] == $past(pin_sync[5]))
      else $error("summary supply bit wrong");
   AST_SYS_RSVD: assert property (@(posedge clk_sys) disable iff (srst) // see [R18]
      reg_rd && reg_addr == ESA_ADDR_SYSTEM |=> (reg_rdata & ~ESA_SYS_MASK) == 8'h00)
      else $error("system reserved bits set");

   // flag setting
   AST_PO_SET: assert property (@(posedge clk_sys) disable iff (srst) // see [R06]
      off_mode_exit |=> sys_flags[ESA_BIT_PO] && power_on_flag) else $error("power-on flag not set");
   AST_OTW_SET: assert property (@(posedge clk_sys) disable iff (srst) // see [R07]
      overtemp_warn && otw_capture_en && !sleep_mode |=> sys_flags[ESA_BIT_OTW])
      else $error("overtemp not flagged");
   AST_OTW_MASK: assert property (@(posedge clk_sys) disable iff (srst) // see [R15]
      overtemp_warn && !otw_capture_en && !sys_flags[ESA_BIT_OTW] |=> !sys_flags[ESA_BIT_OTW])
      else $error("overtemp captured while disabled");
   AST_OTW_SLEEP: assert property (@(posedge clk_sys) disable iff (srst) // see [R07]
      sleep_mode && !sys_flags[ESA_BIT_OTW] && !(reg_wr) |=> !sys_flags[ESA_BIT_OTW])
      else $error("overtemp captured in sleep");
   AST_SF_COUNT: assert property (@(posedge clk_sys) disable iff (srst) // see [R08]
      serial_frame_end && !legal_count(serial_bit_count) && sf_capture_en && !sleep_mode
      |=> sys_flags[ESA_BIT_SF]) else $error("bad count not flagged");
   AST_SF_ILLEGAL: assert property (@(posedge clk_sys) disable iff (srst) // see [R09]
      illegal_code_write && sf_capture_en && !sleep_mode |=> sys_flags[ESA_BIT_SF])
      else $error("illegal code not flagged");
   AST_SF_LOCKED: assert property (@(posedge clk_sys) disable iff (srst) // see [R10]
      locked_write && sf_capture_en && !sleep_mode |=> sys_flags[ESA_BIT_SF])
      else $error("locked write not flagged");
   AST_WDF_EARLY: assert property (@(posedge clk_sys) disable iff (srst) // see [R12]
      wdt_early && wdt_window_mode |=> sys_flags[ESA_BIT_WDF] && watchdog_failure_flag)
      else $error("early service not flagged");

   // watchdog reset and flag, receive-data release after clear
   AST_WIN_OVF_RST: assert property (@(posedge clk_sys) disable iff (srst) // see [R13]
      wdt_overflow && wdt_window_mode |=> system_reset_req) else $error("window overflow reset missing");
   AST_TO_RST: assert property (@(posedge clk_sys) disable iff (srst) // see [R14]
      wdt_overflow && wdt_timeout_mode && sys_flags[ESA_BIT_WDF] |=> system_reset_req)
      else $error("timeout reset missing");
   AST_WDF_SET: assert property (@(posedge clk_sys) disable iff (srst) // see [R11]
      wdt_overflow && wdt_timeout_mode |=> sys_flags[ESA_BIT_WDF]) else $error("watchdog flag not set");
   AST_WIN_RST: assert property (@(posedge clk_sys) disable iff (srst) // see [R13]
      wdt_early && wdt_window_mode |=> system_reset_req) else $error("window reset missing");
   AST_TO_NORST: assert property (@(posedge clk_sys) disable iff (srst) // see [R14]
      wdt_overflow && wdt_timeout_mode && !wdt_window_mode && !sys_flags[ESA_BIT_WDF]
      && !wdt_early |=> !system_reset_req) else $error("timeout reset without flag");
   AST_RXD_REL: assert property (@(posedge clk_sys) disable iff (srst || rstn_low_s) // see [R17]
      any_clear |=> rxd_out [*2]) else $error("rxd not released after clear");

   // receive-data signalling
   AST_RXD_LOW: assert property (@(posedge clk_sys) disable iff (srst) // see [R16]
      !any_clear && !delay_run && off_s && on_s && any_pending |=> !rxd_out)
      else $error("rxd not driven low");
   AST_DELAY_END: assert property (@(posedge clk_sys) disable iff (srst) // see [R17]
      delay_run && !any_clear && !rstn_low_s && delay_cnt >= 32'(EVENT_DELAY_CYC - 1) |=> !delay_run)
      else $error("event delay did not expire");
endmodule

// ==== esa_pkg.sv ====
// Purpose: constants for the event status aggregator
// Assumes: 8-bit register space reached through the serial register port
// Notes:   offsets, field positions, reset values and timing counts
package esa_pkg;
   localparam logic [7:0] ESA_ADDR_SUMMARY = 8'h60;
   localparam logic [7:0] ESA_ADDR_SYSTEM  = 8'h61;
   localparam logic [7:0] ESA_ADDR_SUPPLY  = 8'h62;
   localparam logic [7:0] ESA_ADDR_TRX     = 8'h63;
   localparam logic [7:0] ESA_ADDR_WAKE    = 8'h64;
   localparam int ESA_SUM_WAKE   = 3;
   localparam int ESA_SUM_TRX    = 2;
   localparam int ESA_SUM_SUPPLY = 1;
   localparam int ESA_SUM_SYSTEM = 0;
   localparam int ESA_BIT_PO  = 4;
   localparam int ESA_BIT_OTW = 2;
   localparam int ESA_BIT_SF  = 1;
   localparam int ESA_BIT_WDF = 0;
   localparam logic [7:0] ESA_SYS_MASK  = 8'h17;
   localparam logic [7:0] ESA_SYS_RESET = 8'h00;
   localparam int ESA_CLK_HZ        = 10_000_000;
   localparam int ESA_EVENT_DELAY_US = 1000;
   localparam int ESA_EVENT_DELAY_CYC = (ESA_EVENT_DELAY_US * (ESA_CLK_HZ / 1_000_000));
   localparam int ESA_RST_PULSE_CYC = 1;
endpackage

// ==== esa_sync.sv ====
// Purpose: two-flop synchroniser for a bus of asynchronous levels
// Assumes: inputs are quasi-static levels
// Notes:   the first stage feeds only the second
`timescale 1ns/1ps
module esa_sync #(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         clk_sys,
   input  wire logic         srst,
   // levels
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta;
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         meta <= '0;
         q    <= '0;
      end else begin
         meta <= d;
         q    <= meta;
      end
   end
endmodule

// ==== esa_host.sv ====
// Purpose: host model driving the register port of the event status aggregator
// Assumes: one request at a time, launched just after a rising edge
// Notes:   idle address shows the inverse of the last value; idle data only after a write
`timescale 1ns/1ps
module esa_host (
   // clock
   input  wire logic       clk_sys,
   // register port
   output logic      [7:0] reg_addr,
   output logic      [7:0] reg_wdata,
   output logic            reg_wr,
   output logic            reg_rd,
   input  wire logic [7:0] reg_rdata
);
   initial begin
      reg_addr  = 8'h00;
      reg_wdata = 8'h00;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
   end
   // ones clear flags, zeros leave them
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk_sys);
      reg_wr    <= 1'b0;
      reg_addr  <= ~a;
      reg_wdata <= ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] q);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk_sys);
      reg_rd   <= 1'b0;
      reg_addr <= ~a;
      #1;
      q = reg_rdata;
   endtask
endmodule

// ==== tb.sv ====
// Purpose: self-checking bench for the event status aggregator
// Assumes: event delay shortened to eight cycles
// Notes:   pulses travel in one vector, levels change on or 1 ns after rising edges
`timescale 1ns/1ps
module tb;
   import esa_pkg::*;
   localparam int DLY = 8;
   logic       clk_sys = 1'b0;
   logic       srst    = 1'b1;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, q;
   logic [7:0] ev      = 8'h00;
   logic       reg_wr, reg_rd, rxd_out, system_reset_req, rq;
   logic       power_on_flag, overtemp_warning_flag, serial_failure_flag, watchdog_failure_flag;
   logic       win = 1'b0, tmo = 1'b0, otw_en = 1'b0, sf_en = 1'b1, slp = 1'b0, off = 1'b0, sup = 1'b0;
   logic [2:0] grp = 3'b000;
   logic [5:0] cnt = 6'h00;
   logic [5:0] cnts [4] = '{6'h10, 6'h18, 6'h20, 6'h14};
   int         fail_count = 0, n_checks = 0, cyc = 0;
   initial begin
      forever #50 clk_sys = ~clk_sys;
   end
   esa_host u_esa_host (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata));
   esa_aggregator #(.EVENT_DELAY_CYC(DLY)) u_esa_aggregator (.clk_sys(clk_sys), .srst(srst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .off_mode_exit(ev[0]), .overtemp_warn(ev[1]), .serial_bad_count(ev[2]), .serial_bit_count(cnt),
      .serial_frame_end(ev[3]), .illegal_code_write(ev[4]), .locked_write(ev[5]), .wdt_overflow(ev[6]),
      .wdt_early(ev[7]), .wdt_window_mode(win), .wdt_timeout_mode(tmo), .otw_capture_en(otw_en),
      .sf_capture_en(sf_en), .sleep_mode(slp), .supply_group_in(grp[0]), .transceiver_group_in(grp[1]),
      .wake_pin_group_in(grp[2]), .trx_offline(off), .main_supply_on(sup), .reset_pin_low(1'b0),
      .rxd_out(rxd_out), .system_reset_req(system_reset_req), .power_on_flag(power_on_flag),
      .overtemp_warning_flag(overtemp_warning_flag), .serial_failure_flag(serial_failure_flag),
      .watchdog_failure_flag(watchdog_failure_flag));
   task automatic final_report;
      if (fail_count == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      n_checks++;
      if (g !== e) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic sys(input logic [7:0] e);
      u_esa_host.rd(ESA_ADDR_SYSTEM, q);
      chk("system_event_flags", e, q);
      chk("flag ports", e, {3'b000, power_on_flag, 1'b0, overtemp_warning_flag, serial_failure_flag,
         watchdog_failure_flag});
   endtask
   task automatic sum(input logic [7:0] e);
      u_esa_host.rd(ESA_ADDR_SUMMARY, q);
      chk("global_event_summary", e, q);
   endtask
   task automatic pulse(input int i);
      @(posedge clk_sys);
      ev[i] <= 1'b1;
      @(posedge clk_sys);
      ev <= 8'h00;
      #1;
      rq = system_reset_req;
   endtask
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fail_count++;
         final_report();
      end
   end
   initial begin
      repeat (4) @(posedge clk_sys);
      srst <= 1'b0;
      repeat (3) @(posedge clk_sys);
      #1;
      chk("rxd_out", 8'h01, {7'h00, rxd_out});
      sys(ESA_SYS_RESET);
      sum(8'h00);
      pulse(0);
      sys(8'h10);
      sum(8'h01);
      pulse(1);
      sys(8'h10);
      otw_en <= 1'b1;
      slp    <= 1'b1;
      pulse(1);
      sys(8'h10);
      slp <= 1'b0;
      pulse(1);
      sys(8'h14);
      u_esa_host.wr(ESA_ADDR_SYSTEM, 8'h04);
      sys(8'h10);
      foreach (cnts[k]) begin
         @(posedge clk_sys);
         cnt <= cnts[k];
         pulse(3);
         sys((k == 3) ? 8'h12 : 8'h10);
      end
      for (int i = 2; i < 6; i++) begin
         if (i != 3) begin
            u_esa_host.wr(ESA_ADDR_SYSTEM, 8'h02);
            pulse(i);
            sys(8'h12);
         end
      end
      u_esa_host.wr(ESA_ADDR_SYSTEM, 8'hEA);
      sf_en <= 1'b0;
      pulse(5);
      sys(8'h10);
      u_esa_host.wr(ESA_ADDR_SUMMARY, 8'hFF);
      sum(8'h01);
      for (int g = 0; g < 3; g++) begin
         @(posedge clk_sys);
         grp <= 3'b001 << g;
         repeat (3) @(posedge clk_sys);
         sum(8'h01 | (8'h02 << g));
      end
      grp <= 3'b000;
      tmo <= 1'b1;
      pulse(6);
      chk("system_reset_req", 8'h00, {7'h00, rq});
      sys(8'h11);
      pulse(6);
      chk("system_reset_req", 8'h01, {7'h00, rq});
      tmo <= 1'b0;
      win <= 1'b1;
      u_esa_host.wr(ESA_ADDR_SYSTEM, 8'h01);
      pulse(7);
      chk("system_reset_req", 8'h01, {7'h00, rq});
      sys(8'h11);
      u_esa_host.wr(ESA_ADDR_SYSTEM, 8'h01);
      pulse(6);
      chk("system_reset_req", 8'h01, {7'h00, rq});
      win <= 1'b0;
      off <= 1'b1;
      sup <= 1'b1;
      // the clear above started the event delay; let it run out
      repeat (DLY + 4) @(posedge clk_sys);
      #1;
      chk("rxd_out", 8'h00, {7'h00, rxd_out});
      u_esa_host.wr(ESA_ADDR_SYSTEM, 8'h11);
      @(posedge clk_sys);
      #1;
      chk("rxd_out", 8'h01, {7'h00, rxd_out});
      pulse(0);
      chk("rxd_out", 8'h01, {7'h00, rxd_out});
      repeat (DLY) @(posedge clk_sys);
      #1;
      chk("rxd_out", 8'h00, {7'h00, rxd_out});
      final_report();
   end
endmodule
